// >>> rfs_host.sv
// Management host model: single-word AHB-Lite master.
// Assumes one slave whose hreadyout is fed back as hready.
`default_nettype none
module rfs_host #(
   parameter int HOLD_CYC = 500
) (
   input  wire logic        core_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // ====================
   // Bus cycles
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      // Released lines must not keep looking valid
      haddr <= ~haddr;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic read(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask
   // ====================
   // Restart sequences
   task automatic op_cycle(input logic [31:0] c);
      write(rfs_pkg::ADDR_CTRL, c & ~32'h1);
      repeat (4) @(posedge core_clk);
      write(rfs_pkg::ADDR_CTRL, c | 32'h1);
   endtask
   task automatic pause;
      repeat (HOLD_CYC) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// >>> rfs_pkg.sv
// Constants, register map and carrier types of the rectifier supervisor.
// Assumes a 20 MHz core clock and a 1 ms supervisory tick.
`default_nettype none
package rfs_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_VOUT  = 8'h04;
   localparam logic [7:0] ADDR_STAT  = 8'h08;
   localparam logic [7:0] ADDR_BCAST = 8'h0C;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_OP        = 0;
   localparam int CTRL_OC_LATCH  = 1;
   localparam int CTRL_OT_LATCH  = 2;
   localparam int CTRL_BUS_MODE  = 3;
   localparam int BCAST_ON       = 0;
   localparam logic [3:0]  CTRL_RST  = 4'h1;
   localparam logic [0:0]  BCAST_RST = 1'h1;
   localparam logic [15:0] VOUT_RST  = 16'h0000;

   // ==========================================================
   // Setpoint selection, millivolts
   localparam logic [11:0] VPROG_MIN_MV    = 12'h064;
   localparam logic [11:0] VPROG_MAX_MV    = 12'hBB8;
   localparam logic [15:0] VOUT_DEFAULT_MV = 16'hCB20;

   // ==========================================================
   // Timing
   localparam int CLK_NS       = 50;
   localparam int TICK_NS      = 1000000;
   localparam int TICK_CYCLES  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int GRACE_MS     = 20000;
   localparam int RESTART_MS   = 1000;
   localparam int OV_WINDOW_MS = 60000;
   localparam int BUS_DELAY_MS = 10000;
   localparam int AUX_LEAD_MS  = 450;
   localparam int PG_LEAD_MS   = 3;
   localparam int BLINK_MS     = 250;
   localparam int OV_LIMIT     = 3;

   typedef enum logic [1:0] {SRC_DEFAULT, SRC_PIN, SRC_FW} rfs_src_e;
   typedef enum logic [2:0] {C_NONE, C_OFF, C_AC, C_OV, C_OC, C_OT} rfs_cause_e;

   // Asynchronous pin levels, all active high
   typedef struct packed {
      logic ac_ok;
      logic ac_low;
      logic enable;
      logic aux_ok;
      logic above_10v;
      logic in_limit;
      logic ov_fault;
      logic oc_fault;
      logic ot_fault;
   } rfs_pins_s;
endpackage
`default_nettype wire

// >>> rfs_supervisor.sv
// Rectifier fault and restart supervisor with AHB-Lite register slave.
// Assumes rst is the input-power-on reset; pins are asynchronous.
`default_nettype none
// Summary of operation
// [RQ1] Pin level 0.1-3.0 V sets output setpoint
// [RQ2] Open or high pin selects 52 V
// [RQ3] Vout command takes ownership until power cycles
// [RQ4] Tolerate startup overload for 20 seconds
// [RQ5] Blink output LED while limiting above 10V
// [RQ6] Hiccup below 10 V; LED follows on/off
// [RQ7] Output LED dark in latched shutdown
// [RQ8] Overcurrent/overtemp auto-restart unless latch configured
// [RQ9] Overvoltage: three 1 s restarts, then latch
// [RQ10] Window expiry with few shutdowns clears count
// [RQ11] Enable pin off-then-on clears latch
// [RQ12] Operation off-then-on clears latch
// [RQ13] Broadcast or shared enable restarts all together
// [RQ14] Host keeps units off 20-30 s first; rfs_host pause holds only HOLD_CYC core clocks, 500 by default
// [RQ15] Bus mode waits 10 s after input returns
// [RQ16] Power-good warning 3 ms before output drops
// [RQ17] Blink input LED while input below 80 V
// [RQ18] Aux valid 450 ms before main output
// [RQ19] Delays counted from a prescaled tick
// [RQ20] Per-feature firmware ownership, cleared by reset
module rfs_supervisor #(
   parameter int TICK_CYCLES  = rfs_pkg::TICK_CYCLES,
   parameter int GRACE_MS     = rfs_pkg::GRACE_MS,
   parameter int RESTART_MS   = rfs_pkg::RESTART_MS,
   parameter int OV_WINDOW_MS = rfs_pkg::OV_WINDOW_MS,
   parameter int BUS_DELAY_MS = rfs_pkg::BUS_DELAY_MS
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire rfs_pkg::rfs_pins_s pins,
   input  wire logic [11:0]       vprog_mv,
   output logic [15:0]            vout_set_mv,
   output rfs_pkg::rfs_src_e      vout_src,
   output logic                   aux_en,
   output logic                   main_en,
   output logic                   power_good_warning_n,
   output logic                   out_led,
   output logic                   in_led
);
   typedef enum logic [2:0] {S_AUX, S_DELAY, S_ON, S_WARN, S_WAIT, S_LATCH} rfs_state_e;

   // ==========================================================
   // Pin capture and tick
   rfs_pkg::rfs_pins_s p;
   logic               tick;

   rfs_sync #(.W($bits(rfs_pkg::rfs_pins_s))) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (pins),
      .dout     (p)
   );

   rfs_tick #(.RATIO(TICK_CYCLES)) u_tick ( // RQ19
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick)
   );

   // ==========================================================
   // AHB-Lite slave, zero wait states
   logic [3:0]  ctrl;
   logic [15:0] vout_cmd;
   logic [0:0]  bcast;
   logic        fw_own_vout;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic [31:0] stat_word;

   wire accept   = hsel & hready & htrans[1];
   wire wr_vout  = wr_pend & (wr_addr == rfs_pkg::ADDR_VOUT);
   wire wr_ctrl  = wr_pend & (wr_addr == rfs_pkg::ADDR_CTRL);
   wire wr_bcast = wr_pend & (wr_addr == rfs_pkg::ADDR_BCAST);
   wire [7:0] rd_addr = haddr[7:0];
   wire [31:0] rd_word =
      (rd_addr == rfs_pkg::ADDR_CTRL)  ? {28'h0, ctrl} :
      (rd_addr == rfs_pkg::ADDR_VOUT)  ? {16'h0, vout_cmd} :
      (rd_addr == rfs_pkg::ADDR_STAT)  ? stat_word :
      (rd_addr == rfs_pkg::ADDR_BCAST) ? {31'h0, bcast} : 32'h0;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else begin
         wr_pend <= accept & hwrite;
         if (accept) begin
            wr_addr <= haddr[7:0];
         end
         if (accept & ~hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl        <= rfs_pkg::CTRL_RST;
         vout_cmd    <= rfs_pkg::VOUT_RST;
         bcast       <= rfs_pkg::BCAST_RST;
         fw_own_vout <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= hwdata[3:0];
         end
         if (wr_bcast) begin
            bcast <= hwdata[0:0];
         end
         if (wr_vout) begin
            vout_cmd    <= hwdata[15:0];
            fw_own_vout <= 1'b1; // RQ3 RQ20
         end
      end
   end

   // ==========================================================
   // Setpoint arbitration
   wire pin_valid = (vprog_mv >= rfs_pkg::VPROG_MIN_MV) & (vprog_mv <= rfs_pkg::VPROG_MAX_MV);
   wire [15:0] next_set =
      fw_own_vout ? vout_cmd :                // RQ3
      pin_valid   ? {4'h0, vprog_mv} :        // RQ1
      rfs_pkg::VOUT_DEFAULT_MV;               // RQ2
   wire rfs_pkg::rfs_src_e next_src =
      fw_own_vout ? rfs_pkg::SRC_FW : (pin_valid ? rfs_pkg::SRC_PIN : rfs_pkg::SRC_DEFAULT);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         vout_set_mv <= rfs_pkg::VOUT_DEFAULT_MV;
         vout_src    <= rfs_pkg::SRC_DEFAULT;
      end else begin
         vout_set_mv <= next_set;
         vout_src    <= next_src;
      end
   end

   // ==========================================================
   // Sequencer
   rfs_state_e          state;
   rfs_state_e          next_state;
   rfs_pkg::rfs_cause_e cause;
   rfs_pkg::rfs_cause_e next_cause;
   logic [16:0]         ms;
   logic [14:0]         grace_ms;
   logic [16:0]         win_ms;
   logic [2:0]          ov_cnt;
   logic                run_q;

   // Shared enable and broadcast gate every unit alike
   wire run        = p.enable & ctrl[rfs_pkg::CTRL_OP] & bcast[rfs_pkg::BCAST_ON]; // RQ13
   wire run_rise   = run & ~run_q;                  // RQ11 RQ12
   wire grace_done = (grace_ms >= 15'(GRACE_MS));
   wire hiccup     = p.in_limit & ~p.above_10v;     // RQ6
   wire oc_event   = grace_done & (p.oc_fault | hiccup); // RQ4
   wire ov_latch   = (ov_cnt > 3'(rfs_pkg::OV_LIMIT));
   wire win_end    = (win_ms > 17'(OV_WINDOW_MS));

   always_comb begin
      next_state = state;
      next_cause = cause;
      case (state)
         S_AUX: begin
            if (p.aux_ok && ms > 17'(rfs_pkg::AUX_LEAD_MS)) begin // RQ18
               next_state = S_DELAY;
            end
         end
         S_DELAY: begin
            if (run && p.ac_ok && !p.ot_fault &&
                (!ctrl[rfs_pkg::CTRL_BUS_MODE] || ms > 17'(BUS_DELAY_MS))) begin // RQ15
               next_state = S_ON;
            end
         end
         S_ON: begin
            next_cause = p.ov_fault ? rfs_pkg::C_OV :
                         p.ot_fault ? rfs_pkg::C_OT :
                         oc_event   ? rfs_pkg::C_OC :
                         !p.ac_ok   ? rfs_pkg::C_AC :
                         !run       ? rfs_pkg::C_OFF : rfs_pkg::C_NONE;
            if (next_cause != rfs_pkg::C_NONE) begin
               next_state = S_WARN;
            end
         end
         S_WARN: begin
            if (ms > 17'(rfs_pkg::PG_LEAD_MS)) begin // RQ16
               if ((cause == rfs_pkg::C_OV && ov_latch) ||                        // RQ9
                   (cause == rfs_pkg::C_OC && ctrl[rfs_pkg::CTRL_OC_LATCH]) ||    // RQ8
                   (cause == rfs_pkg::C_OT && ctrl[rfs_pkg::CTRL_OT_LATCH])) begin
                  next_state = S_LATCH;
               end else if (cause == rfs_pkg::C_OFF || cause == rfs_pkg::C_AC) begin
                  next_state = S_DELAY;
               end else begin
                  next_state = S_WAIT;
               end
            end
         end
         S_WAIT: begin
            if (ms > 17'(RESTART_MS)) begin // RQ9
               next_state = S_DELAY;
            end
         end
         S_LATCH: begin
            if (run_rise) begin // RQ11 RQ12
               next_state = S_DELAY;
            end
         end
         default: next_state = S_AUX;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= S_AUX;
         cause <= rfs_pkg::C_NONE;
         run_q <= 1'b0;
      end else begin
         state <= next_state;
         cause <= next_cause;
         run_q <= run;
      end
   end

   // Timers in ms ticks; the state timer restarts on every transition,
   // and DELAY also restarts while input is out of regulation
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ms       <= '0;
         grace_ms <= '0;
      end else begin
         if (next_state != state || (state == S_DELAY && !p.ac_ok)) begin
            ms <= '0;
         end else if (tick && ms != '1) begin
            ms <= ms + 1'b1;
         end
         if (tick && !grace_done) begin
            grace_ms <= grace_ms + 1'b1; // RQ4
         end
      end
   end

   // Overvoltage shutdown count; a new shutdown beats a window reset
   wire ov_hit = (state == S_ON) && (next_cause == rfs_pkg::C_OV);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ov_cnt <= '0;
         win_ms <= '0;
      end else if (ov_hit) begin
         ov_cnt <= ov_cnt + 1'b1;
         if (ov_cnt == '0) begin
            win_ms <= '0;
         end
      end else if (state == S_LATCH && run_rise) begin
         ov_cnt <= '0;
         win_ms <= '0;
      end else if (ov_cnt != '0 && state != S_LATCH) begin
         if (win_end) begin
            ov_cnt <= '0; // RQ10
            win_ms <= '0;
         end else if (tick) begin
            win_ms <= win_ms + 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs and indicators
   logic [7:0] blink_ms;
   logic       blink;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         blink_ms             <= '0;
         blink                <= 1'b0;
         aux_en               <= 1'b0;
         main_en              <= 1'b0;
         power_good_warning_n <= 1'b0;
         out_led              <= 1'b0;
         in_led               <= 1'b0;
      end else begin
         if (tick) begin
            blink_ms <= (blink_ms == 8'(rfs_pkg::BLINK_MS - 1)) ? '0 : blink_ms + 1'b1;
            blink    <= (blink_ms == 8'(rfs_pkg::BLINK_MS - 1)) ? ~blink : blink;
         end
         aux_en               <= 1'b1; // RQ18
         main_en              <= (next_state == S_ON) || (next_state == S_WARN);
         power_good_warning_n <= (next_state == S_ON); // RQ16
         if (next_state == S_LATCH) begin
            out_led <= 1'b0; // RQ7
         end else if (next_state == S_ON && p.in_limit && p.above_10v) begin
            out_led <= blink; // RQ5
         end else begin
            out_led <= (next_state == S_ON); // RQ6
         end
         in_led <= p.ac_low ? blink : p.ac_ok; // RQ17
      end
   end

   assign stat_word = {18'h0, grace_done, fw_own_vout, ov_cnt, cause, 2'h0, state, main_en};

   // ==========================================================
   // Checks
   property p_fw_own;
      @(posedge core_clk) disable iff (rst)
      fw_own_vout |=> fw_own_vout && vout_src == rfs_pkg::SRC_FW;
   endproperty
   a_fw_own: assert property (p_fw_own) else $error("ownership lost"); // RQ3

   property p_default_set;
      @(posedge core_clk) disable iff (rst)
      (!fw_own_vout && !pin_valid) |=> vout_set_mv == rfs_pkg::VOUT_DEFAULT_MV;
   endproperty
   a_default_set: assert property (p_default_set) else $error("default setpoint wrong"); // RQ2

   property p_pin_set;
      @(posedge core_clk) disable iff (rst)
      (!fw_own_vout && pin_valid)
         |=> vout_src == rfs_pkg::SRC_PIN && vout_set_mv[11:0] == $past(vprog_mv);
   endproperty
   a_pin_set: assert property (p_pin_set) else $error("pin setpoint wrong"); // RQ1

   property p_grace;
      @(posedge core_clk) disable iff (rst)
      (state == S_ON && !grace_done && !p.ov_fault && !p.ot_fault && p.ac_ok && run)
         |=> state == S_ON;
   endproperty
   a_grace: assert property (p_grace) else $error("left on during grace"); // RQ4

   property p_latch_led;
      @(posedge core_clk) disable iff (rst)
      state == S_LATCH |-> !out_led && !main_en;
   endproperty
   a_latch_led: assert property (p_latch_led) else $error("led lit while latched"); // RQ7

   property p_pg_lead;
      @(posedge core_clk) disable iff (rst)
      $fell(power_good_warning_n) ##0 main_en |-> main_en [*8];
   endproperty
   a_pg_lead: assert property (p_pg_lead) else $error("output dropped too soon"); // RQ16

   property p_pg_ms;
      @(posedge core_clk) disable iff (rst)
      (state == S_WARN && next_state != S_WARN) |-> ms > 17'(rfs_pkg::PG_LEAD_MS);
   endproperty
   a_pg_ms: assert property (p_pg_ms) else $error("warning shorter than lead"); // RQ16

   property p_restart_delay;
      @(posedge core_clk) disable iff (rst)
      (state == S_WAIT && next_state == S_DELAY) |-> ms > 17'(RESTART_MS);
   endproperty
   a_restart_delay: assert property (p_restart_delay) else $error("restart too early"); // RQ9

   property p_aux_lead;
      @(posedge core_clk) disable iff (rst)
      (state == S_AUX && next_state == S_DELAY) |-> p.aux_ok && ms > 17'(rfs_pkg::AUX_LEAD_MS);
   endproperty
   a_aux_lead: assert property (p_aux_lead) else $error("main before aux lead"); // RQ18

   property p_bus_delay;
      @(posedge core_clk) disable iff (rst)
      (state == S_DELAY && next_state == S_ON && ctrl[rfs_pkg::CTRL_BUS_MODE])
         |-> ms > 17'(BUS_DELAY_MS);
   endproperty
   a_bus_delay: assert property (p_bus_delay) else $error("bus mode delay short"); // RQ15

   property p_latch_exit;
      @(posedge core_clk) disable iff (rst)
      (state == S_LATCH && !run_rise) |=> state == S_LATCH;
   endproperty
   a_latch_exit: assert property (p_latch_exit) else $error("latch left without cycle"); // RQ11

   property p_window;
      @(posedge core_clk) disable iff (rst)
      (win_end && !ov_hit && state != S_LATCH && ov_cnt != '0) |=> ov_cnt == '0;
   endproperty
   a_window: assert property (p_window) else $error("window count not cleared"); // RQ10
endmodule
`default_nettype wire

// >>> rfs_supervisor_tb.sv
// Self-checking bench for rfs_supervisor with shortened timers.
// Assumes rfs_host.sv as the host on the register bus.
`default_nettype none
module rfs_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 20;
   logic               core_clk, rst, aux_en, main_en, out_led, in_led;
   logic               hsel, hwrite, hreadyout, hresp, power_good_warning_n;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [11:0]        vprog_mv;
   logic [15:0]        vout_set_mv;
   logic [31:0]        haddr, hwdata, hrdata, rd;
   wire logic          hready;
   rfs_pkg::rfs_src_e  vout_src;
   rfs_pkg::rfs_pins_s pins;
   int                 mismatches, n_checks;
   assign hready = hreadyout;
   rfs_supervisor #(.TICK_CYCLES(TK), .GRACE_MS(500), .RESTART_MS(10),
                    .OV_WINDOW_MS(200), .BUS_DELAY_MS(20)) i_dut (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
      .vprog_mv(vprog_mv), .vout_set_mv(vout_set_mv), .vout_src(vout_src),
      .aux_en(aux_en), .main_en(main_en), .power_good_warning_n(power_good_warning_n),
      .out_led(out_led), .in_led(in_led));
   rfs_host #(.HOLD_CYC(25 * TK)) i_host (
      .core_clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // ====================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * TK) @(posedge core_clk);
   endtask
   task automatic wmain(input logic v, input int lim);
      int n;
      n = 0;
      while (main_en !== v && n < lim * TK) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ====================
   // Scenarios
   task automatic t_setpoint;
      chk("vset open", rfs_pkg::VOUT_DEFAULT_MV, vout_set_mv);
      chk("src open", rfs_pkg::SRC_DEFAULT, vout_src);
      i_host.read(rfs_pkg::ADDR_CTRL, rd);
      chk("ctrl", rfs_pkg::CTRL_RST, rd);
      i_host.read(8'h10, rd);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, hresp);
      vprog_mv <= 12'h064;
      repeat (4) @(posedge core_clk);
      chk("vset min", 32'h64, vout_set_mv);
      chk("src pin", rfs_pkg::SRC_PIN, vout_src);
      vprog_mv <= 12'hBB9;
      repeat (4) @(posedge core_clk);
      chk("vset high", rfs_pkg::VOUT_DEFAULT_MV, vout_set_mv);
      i_host.write(rfs_pkg::ADDR_VOUT, 32'hBB80);
      vprog_mv <= 12'h7D0;
      repeat (4) @(posedge core_clk);
      chk("vset fw", 32'hBB80, vout_set_mv);
      chk("src fw", rfs_pkg::SRC_FW, vout_src);
      $display("test setpoint done");
   endtask
   task automatic t_startup;
      int n;
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      n = 0;
      while (main_en !== 1'b1 && n < 600 * TK) begin
         @(posedge core_clk);
         n++;
      end
      chk("src repower", rfs_pkg::SRC_PIN, vout_src);
      chk("aux lead", 32'h1, n >= 450 * TK);
      chk("aux on", 32'h1, aux_en);
      chk("main on", 32'h1, main_en);
      chk("pg idle", 32'h1, power_good_warning_n);
      // Grace outlasts the aux lead, so overload right after turn-on is ridden out
      pins.oc_fault <= 1'b1;
      ticks(20);
      chk("grace hold", 32'h1, main_en);
      pins.oc_fault <= 1'b0;
      $display("test startup done");
   endtask
   task automatic t_ov;
      int n;
      int ons;
      logic was;
      pins.ov_fault <= 1'b1;
      n = 0;
      while (power_good_warning_n !== 1'b0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      n = 0;
      while (main_en === 1'b1 && n < 20 * TK) begin
         @(posedge core_clk);
         n++;
      end
      chk("pg lead", 32'h1, n >= 3 * TK);
      n = 0;
      while (main_en !== 1'b1 && n < 30 * TK) begin
         @(posedge core_clk);
         n++;
      end
      chk("restart gap", 32'h1, n >= 10 * TK);
      ons = 1;
      was = 1'b1;
      repeat (150 * TK) begin
         @(posedge core_clk);
         if (main_en === 1'b1 && !was) ons++;
         was = main_en;
      end
      chk("restarts", 32'h3, ons);
      chk("latched", 32'h0, main_en);
      chk("led latched", 32'h0, out_led);
      i_host.read(rfs_pkg::ADDR_STAT, rd);
      chk("state", 32'h5, rd[3:1]);
      pins.ov_fault <= 1'b0;
      pins.enable <= 1'b0;
      repeat (10) @(posedge core_clk);
      pins.enable <= 1'b1;
      wmain(1'b1, 40);
      chk("enable clear", 32'h1, main_en);
      $display("test overvoltage done");
   endtask
   task automatic t_latch_cfg;
      i_host.write(rfs_pkg::ADDR_CTRL, 32'h3);
      pins.oc_fault <= 1'b1;
      wmain(1'b0, 20);
      pins.oc_fault <= 1'b0;
      ticks(30);
      chk("oc latched", 32'h0, main_en);
      i_host.op_cycle(32'h3);
      wmain(1'b1, 40);
      chk("op clear", 32'h1, main_en);
      i_host.write(rfs_pkg::ADDR_CTRL, 32'h1);
      pins.ot_fault <= 1'b1;
      wmain(1'b0, 20);
      chk("ot off", 32'h0, main_en);
      pins.ot_fault <= 1'b0;
      wmain(1'b1, 40);
      chk("ot auto", 32'h1, main_en);
      i_host.write(rfs_pkg::ADDR_BCAST, 32'h0);
      wmain(1'b0, 20);
      chk("bcast off", 32'h0, main_en);
      i_host.pause;
      i_host.write(rfs_pkg::ADDR_BCAST, 32'h1);
      wmain(1'b1, 40);
      chk("bcast on", 32'h1, main_en);
      i_host.write(rfs_pkg::ADDR_CTRL, 32'h9);
      pins.ac_ok <= 1'b0;
      wmain(1'b0, 20);
      pins.ac_ok <= 1'b1;
      ticks(15);
      chk("bus delay hold", 32'h0, main_en);
      wmain(1'b1, 40);
      chk("bus delay on", 32'h1, main_en);
      $display("test latch and broadcast done");
   endtask
   task automatic t_window;
      int ti;
      int to;
      logic li;
      logic lo;
      ticks(210);
      pins.ov_fault <= 1'b1;
      repeat (6) @(posedge core_clk);
      pins.ov_fault <= 1'b0;
      wmain(1'b0, 20);
      i_host.read(rfs_pkg::ADDR_STAT, rd);
      chk("ov count", 32'h1, rd[11:9]);
      ticks(210);
      i_host.read(rfs_pkg::ADDR_STAT, rd);
      chk("ov cleared", 32'h0, rd[11:9]);
      chk("auto on", 32'h1, main_en);
      pins.ac_low <= 1'b1;
      pins.in_limit <= 1'b1;
      pins.above_10v <= 1'b1;
      ti = 0;
      to = 0;
      li = in_led;
      lo = out_led;
      repeat (600 * TK) begin
         @(posedge core_clk);
         if (in_led !== li) ti++;
         if (out_led !== lo) to++;
         li = in_led;
         lo = out_led;
      end
      chk("in blink", 32'h1, ti >= 2);
      chk("out blink", 32'h1, to >= 2);
      $display("test window and leds done");
   endtask
   // ====================
   // Sequence
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #(80000 * 50);
      mismatches++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      vprog_mv = 12'h0;
      // ac_ok, enable and aux_ok high
      pins = 9'h160;
      mismatches = 0;
      n_checks = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_setpoint();
      t_startup();
      t_ov();
      t_latch_cfg();
      t_window();
      summarize();
   end
endmodule
`default_nettype wire

// >>> rfs_sync.sv
// Three-stage pin synchroniser; a level is accepted once stages two and
// three agree. Inputs may come from any clock or none.
`default_nettype none
module rfs_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               s1[i]   <= 1'b0;
               s2[i]   <= 1'b0;
               s3[i]   <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               s1[i] <= din[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  dout[i] <= s3[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> rfs_tick.sv
// Prescaler: one-cycle pulse every RATIO core clocks.
// Assumes RATIO of at least 2.
`default_nettype none
module rfs_tick #(
   parameter int RATIO = 20000
) (
   input  wire logic core_clk,
   input  wire logic rst,
   output logic      tick
);
   localparam int CW = $clog2(RATIO);
   localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
   logic [CW-1:0] cnt;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == LAST);
         cnt  <= (cnt == LAST) ? '0 : cnt + 1'b1;
      end
   end
endmodule
`default_nettype wire
